// ==== inc/vid_mux_pkg.sv ====
// constants, types and register map of the vid code select mux
`default_nettype none
package vid_mux_pkg;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          PULL_TEST_NS  = 4000;
  localparam int          PULL_CYCLES   = (PULL_TEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  PULL_LAST     = 10'(PULL_CYCLES - 1);
  // ahb register map, byte addresses
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam int          CTRL_SAMPLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  // four-level input encodings from the comparator front end
  localparam logic [1:0]  LEVEL_GND  = 2'h0;
  localparam logic [1:0]  LEVEL_REF  = 2'h1;
  localparam logic [1:0]  LEVEL_OPEN = 2'h2;
  localparam logic [1:0]  LEVEL_VCC  = 2'h3;
  // target voltage table in millivolts
  localparam logic [10:0] MV_UPPER_BASE = 11'h6d6;
  localparam logic [10:0] MV_UPPER_STEP = 11'h032;
  localparam logic [10:0] MV_LOWER_BASE = 11'h3cf;
  localparam logic [10:0] MV_LOWER_STEP = 11'h019;
  localparam logic [4:0]  CODE_RESET    = 5'h00;
  localparam logic [10:0] MV_RESET      = 11'h6d6;
  localparam logic [1:0]  AHB_NONSEQ_BIT = 2'h2;

  typedef enum logic [1:0] {src_logic, src_impedance, src_suspend} source_type;
  typedef enum logic {st_idle, st_pull} sample_state_type;

  typedef struct packed {
    logic       busy;
    source_type source;
    logic [4:0] imp_code;
    logic [4:0] dac_code;
  } status_type;
endpackage : vid_mux_pkg
`default_nettype wire

// ==== rtl/vid_code_select_mux.sv ====
// voltage-identification code selector with impedance sampler and ahb-lite status port
// Function
// - suspend select high picks suspend decoder code
// - suspend select low picks code-source selector output
// - source select low passes pin levels continuously
// - latch impedance code on documented edge events
// - low pin gets pullup 4us, rise means high
// - high pin gets pulldown, fall means high
// - unchanged pin level means low impedance bit
// - map code to target millivolts by table
// - two four-level inputs pick suspend code
// - code change starts an output transition
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vid_code_select_mux (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic [4:0]  vid_code_pins_in,
  input  wire logic        code_source_select_in,
  input  wire logic        low_power_state_select_in,
  input  wire logic [1:0]  low_state_code_msd_in,
  input  wire logic [1:0]  low_state_code_lsd_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [4:0]       pull_up_en_out,
  output logic [4:0]       pull_down_en_out,
  output logic [4:0]       dac_code_out,
  output logic [10:0]      dac_target_mv_out,
  output logic             code_change_out
);

  function automatic logic [10:0] code_to_mv(input logic [4:0] code);
    logic [10:0] step;
    step = {7'h00, code[3:0]};
    if (code[4]) begin
      code_to_mv = 11'(vid_mux_pkg::MV_LOWER_BASE - step * vid_mux_pkg::MV_LOWER_STEP);
    end else begin
      code_to_mv = 11'(vid_mux_pkg::MV_UPPER_BASE - step * vid_mux_pkg::MV_UPPER_STEP);
    end
  endfunction : code_to_mv

  function automatic logic [4:0] suspend_code(input logic [1:0] msd, input logic [1:0] lsd);
    // gnd/gnd is 10000 (0.975 v); each step down the table is one 25 mv code
    suspend_code = {1'b1, msd, lsd};
  endfunction : suspend_code

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [10:0] meta_ff;
  logic [10:0] sync_ff;
  logic [4:0]  pins_s;
  logic        zsel_s;
  logic        sus_s;
  logic [1:0]  msd_s;
  logic [1:0]  lsd_s;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= 11'h000;
      sync_ff <= 11'h000;
    end else begin
      meta_ff <= {vid_code_pins_in, code_source_select_in, low_power_state_select_in,
                  low_state_code_msd_in, low_state_code_lsd_in};
      sync_ff <= meta_ff;
    end
  end

  assign pins_s = sync_ff[10:6];
  assign zsel_s = sync_ff[5];
  assign sus_s  = sync_ff[4];
  assign msd_s  = sync_ff[3:2];
  assign lsd_s  = sync_ff[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // sampling triggers
  logic zsel_prev_ff;
  logic sus_prev_ff;
  logic pend_ff;
  logic sw_req_ff;
  logic trigger;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      zsel_prev_ff <= 1'b0;
      sus_prev_ff  <= 1'b0;
    end else begin
      zsel_prev_ff <= zsel_s;
      sus_prev_ff  <= sus_s;
    end
  end

  // prev flops reset low, so a source select held high through power-up looks like a rising edge
  assign trigger = (zsel_s && !zsel_prev_ff) || (sus_prev_ff && !sus_s && zsel_s) || sw_req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // impedance pull test
  vid_mux_pkg::sample_state_type state_ff;
  logic [9:0] cnt_ff;
  logic [4:0] pre_ff;
  logic [4:0] imp_code_ff;
  logic [4:0] pull_up_ff;
  logic [4:0] pull_dn_ff;
  logic       start;
  logic       done;

  assign start = (state_ff == vid_mux_pkg::st_idle) && pend_ff;
  assign done  = (state_ff == vid_mux_pkg::st_pull) && (cnt_ff == 10'h000);

  // a trigger during a test is held, so a late edge still gets its own sample
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_ff <= 1'b0;
    end else if (trigger) begin
      pend_ff <= 1'b1;
    end else if (start) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff   <= vid_mux_pkg::st_idle;
      cnt_ff     <= 10'h000;
      pre_ff     <= 5'h00;
      pull_up_ff <= 5'h00;
      pull_dn_ff <= 5'h00;
    end else begin
      case (state_ff)
        vid_mux_pkg::st_idle: begin
          if (pend_ff) begin
            state_ff   <= vid_mux_pkg::st_pull;
            cnt_ff     <= vid_mux_pkg::PULL_LAST;
            pre_ff     <= pins_s;            // all five pins in one window
            pull_up_ff <= ~pins_s;
            pull_dn_ff <= pins_s;
          end
        end
        vid_mux_pkg::st_pull: begin
          if (cnt_ff == 10'h000) begin
            state_ff   <= vid_mux_pkg::st_idle;
            pull_up_ff <= 5'h00;
            pull_dn_ff <= 5'h00;
          end else begin
            cnt_ff <= cnt_ff - 10'h001;
          end
        end
        default: begin
          state_ff <= vid_mux_pkg::st_idle;
        end
      endcase
    end
  end

  // a pin that followed its pull is high impedance; one that held its level is low
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      imp_code_ff <= 5'h00;
    end else if (done) begin
      imp_code_ff <= pre_ff ^ pins_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection and target
  logic [4:0]             nxt_code;
  vid_mux_pkg::source_type nxt_source;
  vid_mux_pkg::source_type source_ff;
  logic [4:0]             dac_code_ff;
  logic [10:0]            dac_target_ff;
  logic                   code_change_ff;

  always_comb begin
    if (sus_s) begin
      nxt_source = vid_mux_pkg::src_suspend;
      nxt_code   = suspend_code(msd_s, lsd_s);
    end else if (zsel_s) begin
      nxt_source = vid_mux_pkg::src_impedance;
      nxt_code   = imp_code_ff;
    end else begin
      nxt_source = vid_mux_pkg::src_logic;
      nxt_code   = pins_s;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dac_code_ff    <= vid_mux_pkg::CODE_RESET;
      dac_target_ff  <= vid_mux_pkg::MV_RESET;
      source_ff      <= vid_mux_pkg::src_logic;
      code_change_ff <= 1'b0;
    end else begin
      dac_code_ff    <= nxt_code;
      dac_target_ff  <= code_to_mv(nxt_code);
      source_ff      <= nxt_source;
      code_change_ff <= nxt_code != dac_code_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  logic        rd_phase;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  vid_mux_pkg::status_type status;

  assign rd_phase = hsel_in && htrans_in[1] && hready_in;
  assign status   = '{busy: (state_ff == vid_mux_pkg::st_pull) || pend_ff,
                      source: source_ff, imp_code: imp_code_ff, dac_code: dac_code_ff};

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff   <= rd_phase && hwrite_in;
      if (rd_phase) begin
        wr_addr_ff <= haddr_in[7:0];
      end
      if (rd_phase && !hwrite_in && haddr_in[7:0] == vid_mux_pkg::STATUS_OFFSET) begin
        hrdata_ff <= {19'h00000, status};
      end else begin
        hrdata_ff <= vid_mux_pkg::CTRL_RESET;
      end
    end
  end

  // sample request is write-one, self-clearing after one cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sw_req_ff <= 1'b0;
    end else begin
      sw_req_ff <= wr_pend_ff && wr_addr_ff == vid_mux_pkg::CTRL_OFFSET
                   && hwdata_in[vid_mux_pkg::CTRL_SAMPLE_BIT];
    end
  end

  assign hrdata_out        = hrdata_ff;
  assign hreadyout_out     = hreadyout_ff;
  assign hresp_out         = 1'b0;
  assign pull_up_en_out    = pull_up_ff;
  assign pull_down_en_out  = pull_dn_ff;
  assign dac_code_out      = dac_code_ff;
  assign dac_target_mv_out = dac_target_ff;
  assign code_change_out   = code_change_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // helper counters: cycles since the pull test began, and cycles a pending sample has waited
  logic [9:0]  pull_len_ff;
  logic [10:0] pend_wait_ff;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pull_len_ff <= 10'h000;
    end else if (start) begin
      pull_len_ff <= 10'h000;
    end else begin
      pull_len_ff <= pull_len_ff + 10'h001;
    end
  end

  // eleven bits so a stuck request cannot wrap back under the bound unseen
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_wait_ff <= 11'h000;
    end else if (!pend_ff || start) begin
      pend_wait_ff <= 11'h000;
    end else begin
      pend_wait_ff <= pend_wait_ff + 11'h001;
    end
  end

  property p_suspend_pick;
    @(posedge clock_in) disable iff (!reset_n_in)
      sus_s |=> dac_code_ff == suspend_code($past(msd_s), $past(lsd_s));
  endproperty
  a_suspend_pick: assert property (p_suspend_pick) else $error("suspend code not selected");

  property p_imp_pick;
    @(posedge clock_in) disable iff (!reset_n_in)
      (!sus_s && zsel_s && !done) |=> dac_code_ff == imp_code_ff;
  endproperty
  a_imp_pick: assert property (p_imp_pick) else $error("impedance code not selected");

  property p_logic_pick;
    @(posedge clock_in) disable iff (!reset_n_in)
      (!sus_s && !zsel_s) |=> dac_code_ff == $past(pins_s);
  endproperty
  a_logic_pick: assert property (p_logic_pick) else $error("pin code not passed");

  property p_trigger_start;
    @(posedge clock_in) disable iff (!reset_n_in)
      trigger |=> pend_ff;
  endproperty
  a_trigger_start: assert property (p_trigger_start) else $error("sampling request lost");

  // worst case: a trigger in the start cycle waits out one whole pull test
  property p_pend_wait;
    @(posedge clock_in) disable iff (!reset_n_in)
      pend_wait_ff <= 11'(vid_mux_pkg::PULL_CYCLES);
  endproperty
  a_pend_wait: assert property (p_pend_wait) else $error("pending sample never started");

  property p_pull_dir;
    @(posedge clock_in) disable iff (!reset_n_in)
      state_ff == vid_mux_pkg::st_pull |-> pull_up_ff == ~pre_ff && pull_dn_ff == pre_ff;
  endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("pull direction wrong");

  property p_pull_len;
    @(posedge clock_in) disable iff (!reset_n_in)
      state_ff == vid_mux_pkg::st_pull |-> (pull_len_ff == vid_mux_pkg::PULL_LAST) == done;
  endproperty
  a_pull_len: assert property (p_pull_len) else $error("pull test length wrong");

  property p_decide;
    @(posedge clock_in) disable iff (!reset_n_in)
      done |=> imp_code_ff == ($past(pre_ff) ^ $past(pins_s)) && pull_up_ff == 5'h00;
  endproperty
  a_decide: assert property (p_decide) else $error("impedance decision wrong");

  property p_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      !done |=> $stable(imp_code_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("latched code moved");

  property p_target;
    @(posedge clock_in) disable iff (!reset_n_in)
      dac_target_ff == code_to_mv(dac_code_ff);
  endproperty
  a_target: assert property (p_target) else $error("target voltage mismatch");

  property p_change;
    @(posedge clock_in) disable iff (!reset_n_in)
      ##1 (dac_code_ff != $past(dac_code_ff)) |-> code_change_ff;
  endproperty
  a_change: assert property (p_change) else $error("transition not flagged");

  c_sample: cover property (@(posedge clock_in) disable iff (!reset_n_in) done && (pre_ff ^ pins_s) != 5'h00);
  c_suspend: cover property (@(posedge clock_in) disable iff (!reset_n_in) sus_prev_ff && !sus_s && zsel_s);
  c_sw_req: cover property (@(posedge clock_in) disable iff (!reset_n_in) sw_req_ff);
  c_logic: cover property (@(posedge clock_in) disable iff (!reset_n_in) code_change_ff && !zsel_s);

endmodule : vid_code_select_mux
`default_nettype wire

// ==== testbench/tb_vid_code_select_mux.sv ====
// self-checking bench for the vid code select mux
`timescale 1ns/1ps
`default_nettype none
module tb_vid_code_select_mux;
  logic        clock = 0, reset_n = 0, src = 0, low_power_state_select = 0, hsel = 0, hwrite = 0;
  logic [1:0]  msd = 0, lsd = 0, htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
  logic        hready, hresp, chg;
  logic [4:0]  pins, lvl = 0, hiz = 0, pu, pd, dac;
  logic [10:0] mv;
  int          failures = 0, total_checks = 0;

  always #2 clock = ~clock;

  vid_pin_model u_pins (.level_in(lvl), .high_z_in(hiz), .pull_up_en_in(pu), .pull_down_en_in(pd),
                        .pins_out(pins));
  vid_code_select_mux u_dut (.clock_in(clock), .reset_n_in(reset_n), .vid_code_pins_in(pins),
    .code_source_select_in(src), .low_power_state_select_in(low_power_state_select), .low_state_code_msd_in(msd),
    .low_state_code_lsd_in(lsd), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .pull_up_en_out(pu), .pull_down_en_out(pd), .dac_code_out(dac),
    .dac_target_mv_out(mv), .code_change_out(chg));

  ////////////////////////////////////////////////////////////
  function automatic logic [10:0] tgt(input logic [4:0] c);
    tgt = c[4] ? 11'(975 - 25 * c[3:0]) : 11'(1750 - 50 * c[3:0]);
  endfunction : tgt

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic do_reset(input logic s);
    reset_n <= 1'b0;
    @(posedge clock);
    src <= s;
    repeat (9) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : do_reset

  // three edges from input to code; exactly one change pulse per new code
  task automatic settle(input logic [4:0] c);
    int n;
    n = 0;
    repeat (6) begin
      @(posedge clock); #1;
      if (chg === 1'b1) n++;
    end
    chk(32'(dac), 32'(c));
    chk(32'(mv), 32'(tgt(c)));
    chk(n, 1);
  endtask : settle

  // one impedance sample: pulls per pin level, fixed pull length, latched mask m
  task automatic sample(input logic [4:0] m, input logic [4:0] l);
    int k;
    k = 0;
    while ((pu | pd) === 5'h00 && k < 20) begin
      @(posedge clock); #1; k++;
    end
    chk(32'(pu), {27'h0, ~l});
    chk(32'(pd), 32'(l));
    k = 0;
    while ((pu | pd) !== 5'h00 && k < 2000) begin
      @(posedge clock); #1; k++;
    end
    chk(k, vid_mux_pkg::PULL_CYCLES);
    repeat (4) @(posedge clock);
    #1;
    chk(32'(dac), 32'(m));
    chk(32'(mv), 32'(tgt(m)));
  endtask : sample

  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    close_out();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    chk(32'(dac), 32'h0);
    chk(32'(mv), 32'h6d6);
    chk(32'(hready), 32'h1);
    for (int i = 0; i < 32; i++) begin
      lvl <= 5'(i + 1);
      settle(5'(i + 1));
    end
    lvl <= 5'h0a; hiz <= 5'h13;
    settle(5'h0a);
    src <= 1'b1;
    sample(5'h13, 5'h0a);
    lvl <= 5'h1f;
    repeat (6) @(posedge clock);
    chk(32'(dac), 32'h13);
    ahb(1'b0, 32'h4, 32'h0, d);
    chk(d, (32'h1 << 10) | (32'h13 << 5) | 32'h13);
    chk(32'(hresp), 32'h0);
    ahb(1'b0, 32'h8, 32'h0, d);
    chk(d, 32'h0);
    ahb(1'b1, 32'h8, 32'h1, d);
    repeat (4) @(posedge clock);
    chk(32'(pu | pd), 32'h0);
    // the software sample starts 28 cycles after the previous pull test ends
    hiz <= 5'h04;
    ahb(1'b1, 32'h0, 32'h1, d);
    sample(5'h04, 5'h1f);
    low_power_state_select <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      msd <= 2'(i >> 2); lsd <= 2'(i);
      settle(5'(16 + i));
    end
    ahb(1'b0, 32'h4, 32'h0, d);
    chk(d, (32'h2 << 10) | (32'h04 << 5) | 32'h1f);
    hiz <= 5'h1c; lvl <= 5'h00;
    low_power_state_select <= 1'b0;
    sample(5'h1c, 5'h00);
    src <= 1'b0;
    settle(5'h00);
    hiz <= 5'h09; lvl <= 5'h16;
    do_reset(1'b1);
    sample(5'h09, 5'h16);
    close_out();
  end
endmodule : tb_vid_code_select_mux
`default_nettype wire

// ==== testbench/vid_pin_model.sv ====
// far-end model of the five code pins: driven levels plus per-pin series impedance
`timescale 1ns/1ps
`default_nettype none
module vid_pin_model (
  input  wire logic [4:0] level_in,
  input  wire logic [4:0] high_z_in,
  input  wire logic [4:0] pull_up_en_in,
  input  wire logic [4:0] pull_down_en_in,
  output logic [4:0]      pins_out
);
  // a high-z pin (100k or more) yields to the internal pull, a low-z pin (1k or less) never does
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (high_z_in[i] && pull_up_en_in[i])
        pins_out[i] = 1'b1;
      else if (high_z_in[i] && pull_down_en_in[i])
        pins_out[i] = 1'b0;
      else
        pins_out[i] = level_in[i]; // a low-z or unpulled bit follows level_in in one step
    end
  end
endmodule : vid_pin_model
`default_nettype wire
